// file: rtl/rsoc_pkg.sv
package rsoc_pkg;

	// register offsets (byte-wide map, plain port)
	localparam logic [7:0] RSOC_OFS_AMP_POWER  = 8'h19;
	localparam logic [7:0] RSOC_OFS_AMP_BIAS   = 8'h1A;
	localparam logic [7:0] RSOC_OFS_OSC_DIV    = 8'h1B;
	localparam logic [7:0] RSOC_OFS_SYN_INT    = 8'h1C;
	localparam logic [7:0] RSOC_OFS_SYN_MID    = 8'h1D;
	localparam logic [7:0] RSOC_OFS_SYN_HIGH   = 8'h1E;
	localparam logic [7:0] RSOC_OFS_PUMP       = 8'h1F;
	localparam logic [7:0] RSOC_OFS_OSC_SEL    = 8'h21;
	localparam logic [7:0] RSOC_OFS_PAGE       = 8'h3E;

	// field positions
	localparam int RSOC_POS_POWER_MSB  = 5;
	localparam int RSOC_POS_BIAS_LSB   = 2;
	localparam int RSOC_POS_FREEZE     = 7;
	localparam int RSOC_POS_GATE       = 6;
	localparam int RSOC_POS_PHASE      = 5;
	localparam int RSOC_POS_HIBAND     = 4;
	localparam int RSOC_POS_RATIO_MSB  = 3;
	localparam int RSOC_POS_INT_MSB    = 6;
	localparam int RSOC_POS_SINK       = 6;
	localparam int RSOC_POS_SOURCE     = 5;
	localparam int RSOC_POS_OFS_DIS    = 4;
	localparam int RSOC_POS_OFS_HALF   = 3;
	localparam int RSOC_POS_OSC_MSB    = 1;
	localparam int RSOC_POS_PAGE_MSB   = 4;

	// reset values (none printed; safe choices)
	localparam logic [5:0] RSOC_RST_POWER = 6'h01;
	localparam logic [1:0] RSOC_RST_BIAS  = 2'h3;
	localparam logic [3:0] RSOC_RST_RATIO = 4'h0;
	localparam logic [6:0] RSOC_RST_INT   = 7'h00;
	localparam logic [7:0] RSOC_RST_BYTE  = 8'h00;
	localparam logic [1:0] RSOC_RST_OSC   = 2'h0;
	localparam logic [4:0] RSOC_RST_PAGE  = 5'h00;

	// divider ratio codes; forbidden oscillator and power codes
	localparam logic [3:0] RSOC_RATIO_DIV2  = 4'h0;
	localparam logic [3:0] RSOC_RATIO_DIV4  = 4'h2;
	localparam logic [3:0] RSOC_RATIO_DIV8  = 4'h8;
	localparam logic [3:0] RSOC_RATIO_CHAIN = 4'hF;
	localparam logic [1:0] RSOC_OSC_BAD     = 2'h1;
	localparam logic [5:0] RSOC_POWER_BAD   = 6'h00;

	typedef enum logic [1:0] {RSOC_OSC_OFF, RSOC_OSC_FORBID, RSOC_OSC_MID, RSOC_OSC_HIGH}
		rsoc_osc_t;

	// register port request
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} rsoc_req_t;

	// analog controls
	typedef struct packed {
		logic [5:0]  power_level;
		logic        power_max;
		logic [1:0]  bias_code;
		logic        bias_low_level;
		logic        freeze;
		logic        clock_gate;
		logic        clock_invert;
		logic        high_band_bias;
		logic [3:0]  ratio;
		logic        ratio_chain;
		logic [6:0]  integer_n;
		logic [15:0] fraction_k;
		logic        pump_sink;
		logic        pump_source;
		logic        pump_offset_on;
		logic        pump_offset_half;
		rsoc_osc_t   osc;
		logic [4:0]  page;
	} rsoc_ctl_t;

endpackage

// file: rtl/rsoc_regs.sv
// Behaviour
// - the six-bit output power code 1..62 is graded, 63 is maximum, 0 must never be used.
// - the two-bit bias code picks stage currents; 0..2 high level, 3 the lower level.
// - the freeze bit set to 1 holds the half divider output, 0 lets it run.
// - the clock gate bit set to 1 passes clock to the quadrature half divider.
// - the clock phase bit inverts the quadrature divider clock by 180 degrees when 1.
// - the divider ratio code 0, 2, 8 gives divide by 2, 4, 8; 15 takes the chained input.
// - the integer divisor N lives in bits 6 to 0 of its own register.
// - the lower fraction byte holds K bits 15 to 8, printed range 0 to 127.
// - the upper fraction byte holds the top of K; placement taken as K bits 7 to 0.
// - the force sink bit makes the charge pump sink current when 1.
// - the force source bit makes the charge pump source current when 1.
// - the pump offset disable bit is inverted: 0 enables the offset current.
// - the offset proportion bit gives 10 percent at 0 and 5 percent at 1.
// - the oscillator select code 0 is off, 2 mid, 3 high, 1 must never be written.
// - the page select field at 3E defaults to page 0; page 1 is debug only.
module rsoc_regs
(
	// clock and reset
	input  wire logic            clk,
	input  wire logic            sys_rst,
	// register port
	input  wire rsoc_pkg::rsoc_req_t req,
	output logic [7:0]           rdata,
	// analog controls
	output rsoc_pkg::rsoc_ctl_t  ctl,
	// sticky illegal code flag
	output logic                 bad_code_seen
);
	import rsoc_pkg::*;

	logic [5:0] power_reg;
	logic [5:0] power_next;
	logic [1:0] bias_reg;
	logic [1:0] bias_next;
	logic [7:0] lo_reg;
	logic [7:0] lo_next;
	logic [6:0] int_reg;
	logic [6:0] int_next;
	logic [7:0] mid_reg;
	logic [7:0] mid_next;
	logic [7:0] high_reg;
	logic [7:0] high_next;
	logic [3:0] pump_reg;
	logic [3:0] pump_next;
	logic [1:0] osc_reg;
	logic [1:0] osc_next;
	logic [4:0] page_reg;
	logic [4:0] page_next;
	logic [7:0] rdata_next;
	logic       bad_reg;
	logic       bad_next;

	// address decode
	wire hit_power = req.addr == RSOC_OFS_AMP_POWER;
	wire hit_bias  = req.addr == RSOC_OFS_AMP_BIAS;
	wire hit_lo    = req.addr == RSOC_OFS_OSC_DIV;
	wire hit_int   = req.addr == RSOC_OFS_SYN_INT;
	wire hit_mid   = req.addr == RSOC_OFS_SYN_MID;
	wire hit_high  = req.addr == RSOC_OFS_SYN_HIGH;
	wire hit_pump  = req.addr == RSOC_OFS_PUMP;
	wire hit_osc   = req.addr == RSOC_OFS_OSC_SEL;
	wire hit_page  = req.addr == RSOC_OFS_PAGE;
	wire hit_any   = hit_power || hit_bias || hit_lo || hit_int || hit_mid || hit_high
		|| hit_pump || hit_osc || hit_page;

	// write enables; the port never raises both strobes at once
	wire we_power = req.wr && hit_power;
	wire we_bias  = req.wr && hit_bias;
	wire we_lo    = req.wr && hit_lo;
	wire we_int   = req.wr && hit_int;
	wire we_mid   = req.wr && hit_mid;
	wire we_high  = req.wr && hit_high;
	wire we_pump  = req.wr && hit_pump;
	wire we_osc   = req.wr && hit_osc;
	wire we_page  = req.wr && hit_page;

	// forbidden codes are still stored; flagged sticky for the host to see
	wire bad_power = req.wr && hit_power &&
		req.wdata[RSOC_POS_POWER_MSB:0] == RSOC_POWER_BAD;
	wire ratio_legal = req.wdata[RSOC_POS_RATIO_MSB:0] == RSOC_RATIO_DIV2
		|| req.wdata[RSOC_POS_RATIO_MSB:0] == RSOC_RATIO_DIV4
		|| req.wdata[RSOC_POS_RATIO_MSB:0] == RSOC_RATIO_DIV8
		|| req.wdata[RSOC_POS_RATIO_MSB:0] == RSOC_RATIO_CHAIN;
	wire bad_ratio = req.wr && hit_lo && !ratio_legal;
	wire bad_osc   = req.wr && hit_osc &&
		req.wdata[RSOC_POS_OSC_MSB:0] == RSOC_OSC_BAD;

	// next values: immediate effect, no staging
	assign power_next = we_power ? req.wdata[RSOC_POS_POWER_MSB:0] : power_reg;
	assign bias_next  = we_bias ?
		req.wdata[RSOC_POS_BIAS_LSB+1:RSOC_POS_BIAS_LSB] : bias_reg;
	assign lo_next    = we_lo ? req.wdata : lo_reg;
	assign int_next   = we_int ? req.wdata[RSOC_POS_INT_MSB:0] : int_reg;
	assign mid_next   = we_mid ? req.wdata : mid_reg;
	assign high_next  = we_high ? req.wdata : high_reg;
	assign pump_next  = we_pump ?
		req.wdata[RSOC_POS_SINK:RSOC_POS_OFS_HALF] : pump_reg;
	assign osc_next   = we_osc ? req.wdata[RSOC_POS_OSC_MSB:0] : osc_reg;
	assign page_next  = we_page ? req.wdata[RSOC_POS_PAGE_MSB:0] : page_reg;
	// cleared by reset or by a read of the page register; a new bad write wins
	assign bad_next   = bad_power || bad_ratio || bad_osc ||
		(bad_reg && !(req.rd && hit_page));

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			power_reg <= RSOC_RST_POWER;
		else
			power_reg <= power_next;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			bias_reg <= RSOC_RST_BIAS;
		else
			bias_reg <= bias_next;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			lo_reg <= {RSOC_RST_BYTE[7:4], RSOC_RST_RATIO};
		else
			lo_reg <= lo_next;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			int_reg <= RSOC_RST_INT;
		else
			int_reg <= int_next;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			mid_reg <= RSOC_RST_BYTE;
		else
			mid_reg <= mid_next;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			high_reg <= RSOC_RST_BYTE;
		else
			high_reg <= high_next;
	end

	// reset leaves the offset current on at ten percent
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			pump_reg <= RSOC_RST_BYTE[3:0];
		else
			pump_reg <= pump_next;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			osc_reg <= RSOC_RST_OSC;
		else
			osc_reg <= osc_next;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			page_reg <= RSOC_RST_PAGE;
		else
			page_reg <= page_next;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			bad_reg <= 1'b0;
		else
			bad_reg <= bad_next;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			rdata <= RSOC_RST_BYTE;
		else
			rdata <= rdata_next;
	end

	// read mux; unmapped and write cycles return zero
	wire [7:0] rd_power = {2'h0, power_reg};
	wire [7:0] rd_bias  = {4'h0, bias_reg, 2'h0};
	wire [7:0] rd_lo    = lo_reg;
	wire [7:0] rd_int   = {1'b0, int_reg};
	wire [7:0] rd_mid   = mid_reg;
	wire [7:0] rd_high  = high_reg;
	wire [7:0] rd_pump  = {1'b0, pump_reg, 3'h0};
	wire [7:0] rd_osc   = {6'h00, osc_reg};
	wire [7:0] rd_page  = {3'h0, page_reg};
	assign rdata_next = {8{req.rd}} & (
		({8{hit_power}} & rd_power) |
		({8{hit_bias}} & rd_bias) |
		({8{hit_lo}} & rd_lo) |
		({8{hit_int}} & rd_int) |
		({8{hit_mid}} & rd_mid) |
		({8{hit_high}} & rd_high) |
		({8{hit_pump}} & rd_pump) |
		({8{hit_osc}} & rd_osc) |
		({8{hit_page}} & rd_page));

	assign bad_code_seen = bad_reg;

	// decoded analog controls
	assign ctl.power_level      = power_reg;
	assign ctl.power_max        = &power_reg;
	assign ctl.bias_code        = bias_reg;
	assign ctl.bias_low_level   = &bias_reg;
	assign ctl.freeze           = lo_reg[RSOC_POS_FREEZE];
	assign ctl.clock_gate       = lo_reg[RSOC_POS_GATE];
	assign ctl.clock_invert     = lo_reg[RSOC_POS_PHASE];
	assign ctl.high_band_bias   = lo_reg[RSOC_POS_HIBAND];
	assign ctl.ratio            = lo_reg[RSOC_POS_RATIO_MSB:0];
	assign ctl.ratio_chain      = lo_reg[RSOC_POS_RATIO_MSB:0] == RSOC_RATIO_CHAIN;
	assign ctl.integer_n        = int_reg;
	// placement of the upper byte is uncertain; low byte kept as a plain append
	assign ctl.fraction_k       = {mid_reg, high_reg};
	assign ctl.pump_sink        = pump_reg[3];
	assign ctl.pump_source      = pump_reg[2];
	assign ctl.pump_offset_on   = !pump_reg[1];
	assign ctl.pump_offset_half = pump_reg[0];
	assign ctl.osc              = rsoc_osc_t'(osc_reg);
	assign ctl.page             = page_reg;

	// checks
	a_power_store: assert property (@(posedge clk) disable iff (sys_rst)
		req.wr && hit_power |=> ctl.power_level == $past(req.wdata[5:0]))
		else $error("power field not stored");
	a_bias_low: assert property (@(posedge clk) disable iff (sys_rst)
		req.wr && hit_bias && req.wdata[3:2] == 2'h3 |=> ctl.bias_low_level)
		else $error("bias code 3 not low level");
	a_freeze_hold: assert property (@(posedge clk) disable iff (sys_rst)
		!(req.wr && hit_lo) |=> ctl.freeze == $past(ctl.freeze))
		else $error("freeze changed without write");
	a_gate_store: assert property (@(posedge clk) disable iff (sys_rst)
		req.wr && hit_lo |=> ctl.clock_gate == $past(req.wdata[6]))
		else $error("clock gate not stored");
	a_phase_store: assert property (@(posedge clk) disable iff (sys_rst)
		req.wr && hit_lo |=> ctl.clock_invert == $past(req.wdata[5]))
		else $error("clock phase not stored");
	a_chain_sel: assert property (@(posedge clk) disable iff (sys_rst)
		req.wr && hit_lo && req.wdata[3:0] == 4'hF |=> ctl.ratio_chain)
		else $error("chain code not decoded");
	a_int_width: assert property (@(posedge clk) disable iff (sys_rst)
		req.rd && hit_int |=> rdata[7] == 1'b0)
		else $error("integer bit 7 not zero");
	a_pump_forces: assert property (@(posedge clk) disable iff (sys_rst)
		req.wr && hit_pump |=> ctl.pump_sink == $past(req.wdata[6])
			&& ctl.pump_source == $past(req.wdata[5]))
		else $error("pump force bits wrong");
	a_offset_sense: assert property (@(posedge clk) disable iff (sys_rst)
		req.wr && hit_pump |=> ctl.pump_offset_on == !$past(req.wdata[4])
			&& ctl.pump_offset_half == $past(req.wdata[3]))
		else $error("offset sense wrong");
	a_bad_osc: assert property (@(posedge clk) disable iff (sys_rst)
		bad_osc |=> bad_code_seen)
		else $error("forbidden oscillator code not flagged");
	a_page_reset: assert property (@(posedge clk)
		sys_rst |=> ctl.page == 5'h00)
		else $error("page not zero after reset");
	a_readback: assert property (@(posedge clk) disable iff (sys_rst)
		req.wr && hit_mid ##1 req.rd && hit_mid && !req.wr |=> rdata == $past(req.wdata, 2))
		else $error("readback mismatch");
	a_fraction_k: assert property (@(posedge clk) disable iff (sys_rst)
		req.wr && hit_mid |=> ctl.fraction_k[15:8] == $past(req.wdata))
		else $error("fraction mid byte misplaced");

	// field storage, decode, read-back, flag and reset
	a_power_max: assert property (@(posedge clk) disable iff (sys_rst)
		req.wr && hit_power && req.wdata[5:0] == 6'h3F |=> ctl.power_max)
		else $error("power code 63 not maximum");
	a_power_graded: assert property (@(posedge clk) disable iff (sys_rst)
		req.wr && hit_power && req.wdata[5:0] != 6'h3F |=> !ctl.power_max)
		else $error("graded power taken as maximum");
	a_power_flag: assert property (@(posedge clk) disable iff (sys_rst)
		bad_power |=> bad_code_seen)
		else $error("power code 0 not flagged");
	a_bias_store: assert property (@(posedge clk) disable iff (sys_rst)
		req.wr && hit_bias |=> ctl.bias_code == $past(req.wdata[3:2]))
		else $error("bias code not stored");
	a_bias_high: assert property (@(posedge clk) disable iff (sys_rst)
		req.wr && hit_bias && req.wdata[3:2] != 2'h3 |=> !ctl.bias_low_level)
		else $error("bias codes 0 to 2 not high level");
	a_bias_readback: assert property (@(posedge clk) disable iff (sys_rst)
		req.rd && hit_bias |=> rdata[7:4] == 4'h0 && rdata[1:0] == 2'h0)
		else $error("bias spare bits not zero");
	a_reset_values: assert property (@(posedge clk)
		sys_rst |=> ctl.power_level == RSOC_RST_POWER && ctl.bias_code == RSOC_RST_BIAS
			&& !bad_code_seen && rdata == 8'h00)
		else $error("reset values wrong");
	a_freeze_store: assert property (@(posedge clk) disable iff (sys_rst)
		req.wr && hit_lo |=> ctl.freeze == $past(req.wdata[7]))
		else $error("freeze bit not stored");
	a_hiband_store: assert property (@(posedge clk) disable iff (sys_rst)
		req.wr && hit_lo |=> ctl.high_band_bias == $past(req.wdata[4]))
		else $error("high band bias not stored");
	a_ratio_store: assert property (@(posedge clk) disable iff (sys_rst)
		req.wr && hit_lo |=> ctl.ratio == $past(req.wdata[3:0]))
		else $error("divider ratio not stored");
	a_chain_other: assert property (@(posedge clk) disable iff (sys_rst)
		req.wr && hit_lo && req.wdata[3:0] != 4'hF |=> !ctl.ratio_chain)
		else $error("chain decoded from another code");
	a_ratio_flag: assert property (@(posedge clk) disable iff (sys_rst)
		bad_ratio |=> bad_code_seen)
		else $error("illegal ratio not flagged");
	a_ratio_legal: assert property (@(posedge clk) disable iff (sys_rst)
		!bad_code_seen && req.wr && hit_lo && ratio_legal |=> !bad_code_seen)
		else $error("legal ratio flagged");
	a_int_store: assert property (@(posedge clk) disable iff (sys_rst)
		req.wr && hit_int |=> ctl.integer_n == $past(req.wdata[6:0]))
		else $error("integer divisor not stored");
	a_int_readback: assert property (@(posedge clk) disable iff (sys_rst)
		req.rd && hit_int |=> rdata[6:0] == $past(ctl.integer_n))
		else $error("integer divisor read wrong");
	a_fraction_low: assert property (@(posedge clk) disable iff (sys_rst)
		req.wr && hit_high |=> ctl.fraction_k[7:0] == $past(req.wdata))
		else $error("fraction high byte misplaced");
	a_high_readback: assert property (@(posedge clk) disable iff (sys_rst)
		req.rd && hit_high |=> rdata == $past(ctl.fraction_k[7:0]))
		else $error("fraction high byte read wrong");
	a_pump_hold: assert property (@(posedge clk) disable iff (sys_rst)
		!(req.wr && hit_pump) |=> $stable(ctl.pump_source) && $stable(ctl.pump_sink))
		else $error("pump force changed without write");
	a_pump_readback: assert property (@(posedge clk) disable iff (sys_rst)
		req.wr && hit_pump ##1 req.rd && hit_pump && !req.wr
			|=> rdata == {1'b0, $past(req.wdata[6:3], 2), 3'h0})
		else $error("pump readback mismatch");
	a_osc_store: assert property (@(posedge clk) disable iff (sys_rst)
		req.wr && hit_osc |=> ctl.osc == rsoc_osc_t'($past(req.wdata[1:0])))
		else $error("oscillator select not stored");
	a_osc_readback: assert property (@(posedge clk) disable iff (sys_rst)
		req.rd && hit_osc |=> rdata[7:2] == 6'h00)
		else $error("oscillator spare bits not zero");
	a_page_store: assert property (@(posedge clk) disable iff (sys_rst)
		req.wr && hit_page |=> ctl.page == $past(req.wdata[4:0]))
		else $error("page not stored");
	a_page_readback: assert property (@(posedge clk) disable iff (sys_rst)
		req.rd && hit_page |=> rdata == {3'h0, $past(ctl.page)})
		else $error("page read wrong");
	a_flag_clear: assert property (@(posedge clk) disable iff (sys_rst)
		req.rd && hit_page && !req.wr |=> !bad_code_seen)
		else $error("flag not cleared by page read");
	a_flag_sticky: assert property (@(posedge clk) disable iff (sys_rst)
		bad_code_seen && !(req.rd && hit_page) |=> bad_code_seen)
		else $error("flag dropped without page read");
	a_rdata_idle: assert property (@(posedge clk) disable iff (sys_rst)
		!req.rd |=> rdata == 8'h00)
		else $error("read data not zero without read");
	a_rdata_unmapped: assert property (@(posedge clk) disable iff (sys_rst)
		req.rd && !hit_any |=> rdata == 8'h00)
		else $error("unmapped read not zero");
	a_lo_readback: assert property (@(posedge clk) disable iff (sys_rst)
		req.rd && hit_lo |=> rdata == {ctl.freeze, ctl.clock_gate, ctl.clock_invert,
			ctl.high_band_bias, ctl.ratio})
		else $error("divider control read wrong");

	c_chain_mode: cover property (@(posedge clk) req.wr && hit_lo && req.wdata[3:0] == 4'hF);
	c_max_power: cover property (@(posedge clk) req.wr && hit_power && req.wdata[5:0] == 6'h3F);
	c_write_read: cover property (@(posedge clk) req.wr && hit_pump ##1 req.rd && hit_pump);
	c_bad_flag: cover property (@(posedge clk) bad_code_seen);
	c_debug_page: cover property (@(posedge clk) req.wr && hit_page && req.wdata[4:0] == 5'h01);

endmodule

// file: verification/rsoc_host_model.sv
module rsoc_host_model
(
	// clock
	input  wire logic          clk,
	// register port
	output rsoc_pkg::rsoc_req_t req,
	input  wire logic [7:0]    rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	import rsoc_pkg::*;

	initial req = '0;

	// one strobe cycle; released lines show the inverse so stale values never match
	task automatic put(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		req <= '{wr: w, rd: !w, addr: a, wdata: d};
		@(posedge clk);
		req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		put(1'b0, a, 8'h00);
		@(negedge clk);
		d = rdata;
	endtask

	// write then read with no gap, as the port allows
	task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
		@(posedge clk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~d};
		@(posedge clk);
		req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: d};
		@(negedge clk);
		q = rdata;
	endtask

	// random value a well-behaved host may write; spare bits stay random except at the page register, written as zero
	function automatic logic [7:0] pick(input logic [7:0] a);
		logic [7:0] v;
		v = 8'($urandom);
		case (a)
			RSOC_OFS_AMP_POWER: v[5:0] = (v[5:0] == 6'h00) ? 6'h3F : v[5:0];
			RSOC_OFS_OSC_DIV: v[3:0] = v[1] ? (v[0] ? RSOC_RATIO_CHAIN : RSOC_RATIO_DIV8)
				: (v[0] ? RSOC_RATIO_DIV4 : RSOC_RATIO_DIV2);
			RSOC_OFS_OSC_SEL: v[1] = v[1] | v[0];
			RSOC_OFS_PAGE: v = 8'h00;
			default: v = v;
		endcase
		// high band bias only with the divide-by-two ratio
		if (a == RSOC_OFS_OSC_DIV)
			v[4] = (v[3:0] == RSOC_RATIO_DIV2);
		return v;
	endfunction
endmodule

// file: verification/rsoc_regs_tb_top.sv
module rsoc_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import rsoc_pkg::*;

	logic       clk = 1'b0;
	logic       sys_rst = 1'b1;
	rsoc_req_t  req;
	logic [7:0] rdata;
	rsoc_ctl_t  ctl;
	logic       bad_code_seen;
	int         err_total = 0;
	int         tests_run = 0;
	int         idx;
	logic [7:0] got;
	logic [7:0] val;
	logic [7:0] sh [9];
	localparam logic [7:0] ADR [9] = '{RSOC_OFS_AMP_POWER, RSOC_OFS_AMP_BIAS, RSOC_OFS_OSC_DIV,
		RSOC_OFS_SYN_INT, RSOC_OFS_SYN_MID, RSOC_OFS_SYN_HIGH, RSOC_OFS_PUMP, RSOC_OFS_OSC_SEL,
		RSOC_OFS_PAGE};
	localparam logic [7:0] MSK [9] = '{8'h3F, 8'h0C, 8'hFF, 8'h7F, 8'hFF, 8'hFF, 8'h78, 8'h03, 8'h1F};
	localparam logic [7:0] RST [9] = '{8'h01, 8'h0C, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

	always #10 clk = ~clk;

	rsoc_regs dut (.clk(clk), .sys_rst(sys_rst), .req(req), .rdata(rdata), .ctl(ctl),
		.bad_code_seen(bad_code_seen));
	rsoc_host_model host (.clk(clk), .req(req), .rdata(rdata));

	function automatic rsoc_ctl_t expect_ctl();
		rsoc_ctl_t e;
		e.power_level = sh[0][5:0];
		e.power_max = sh[0][5:0] == 6'h3F;
		e.bias_code = sh[1][3:2];
		e.bias_low_level = sh[1][3:2] == 2'h3;
		{e.freeze, e.clock_gate, e.clock_invert, e.high_band_bias, e.ratio} = sh[2];
		e.ratio_chain = sh[2][3:0] == RSOC_RATIO_CHAIN;
		e.integer_n = sh[3][6:0];
		e.fraction_k = {sh[4], sh[5]};
		{e.pump_sink, e.pump_source} = sh[6][6:5];
		e.pump_offset_on = !sh[6][4];
		e.pump_offset_half = sh[6][3];
		e.osc = rsoc_osc_t'(sh[7][1:0]);
		e.page = sh[8][4:0];
		return e;
	endfunction

	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			err_total++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic wr(input int i, input logic [7:0] d);
		host.put(1'b1, ADR[i], d);
		sh[i] = d & MSK[i];
	endtask

	task automatic sweep();
		rsoc_ctl_t e;
		for (int i = 0; i < 9; i++)
		begin
			host.rd(ADR[i], got);
			check("rdata", got, sh[i]);
		end
		e = expect_ctl();
		check("ctl amp lo", ctl[52:34], e[52:34]);
		check("ctl synth", ctl[33:0], e[33:0]);
	endtask

	initial
	begin
		#400000;
		err_total++;
		close_out();
	end

	initial
	begin
		void'($urandom(43));
		sh = RST;
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		sweep();
		check("bad flag", bad_code_seen, 1'b0);
		$display("test reset done");
		repeat (60)
		begin
			idx = $urandom % 9;
			wr(idx, host.pick(ADR[idx]));
			if ($urandom % 4 == 0)
				sweep();
		end
		sweep();
		// back-to-back write and read of the same register
		for (int i = 4; i < 7; i += 2)
		begin
			val = host.pick(ADR[i]);
			host.wr_rd(ADR[i], val, got);
			sh[i] = val & MSK[i];
			check("back to back", got, sh[i]);
		end
		sweep();
		$display("test random done");
		// debug page selected once, then back to the normal page
		wr(8, 8'h01);
		sweep();
		wr(8, 8'h00);
		host.put(1'b1, 8'h20, 8'hA5);
		host.rd(8'h20, got);
		check("unmapped", got, 8'h00);
		@(negedge clk);
		check("rdata idle", rdata, 8'h00);
		sweep();
		$display("test unmapped done");
		// forbidden codes are stored but flagged; reading the page clears the flag
		foreach (RST[k])
		begin
			if (k == 0 || k == 2 || k == 7)
			begin
				wr(k, (k == 0) ? 8'hC0 : 8'h01);
				@(negedge clk);
				check("bad flag set", bad_code_seen, 1'b1);
				host.rd(ADR[8], got);
				check("bad flag clear", bad_code_seen, 1'b0);
				sweep();
			end
		end
		$display("test forbidden done");
		// leave the flag set so the reset has something to clear
		wr(0, 8'hC0);
		@(posedge clk);
		sys_rst <= 1'b1;
		@(posedge clk);
		sys_rst <= 1'b0;
		sh = RST;
		@(negedge clk);
		check("bad flag reset", bad_code_seen, 1'b0);
		sweep();
		$display("test second reset done");
		close_out();
	end
endmodule
